// File: src/ccs_flags.sv
// CPU cycle-phase state, program flags and device flags with AXI4-Lite view
`timescale 1ns/1ps
`default_nettype none

module ccs_flags (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Sequencer: memory cycles and phases
  input  wire logic                         cycle_start,
  input  wire ccs_pkg::ccs_phase_t          cycle_req,
  input  wire logic                         mem_ref_instr,
  input  wire logic                         multi_cycle_instr,
  input  wire logic                         exec2_instr,
  // Sequencer: flag instructions
  input  wire logic                         set_flag_instr,
  input  wire logic                         reset_flag_instr,
  input  wire logic                         branch_on_flag_instr,
  input  wire logic [ccs_pkg::CCS_SEL_W-1:0] flag_sel,
  output logic                              flag_test_valid,
  output logic                              flag_test_result,
  // Shift and interrupt
  input  wire logic                         shift_start,
  input  wire logic [4:0]                   shift_count,
  input  wire logic                         shift_done,
  input  wire logic                         int_enable_instr,
  input  wire logic                         int_disable_instr,
  input  wire logic                         int_taken,
  input  wire logic                         panel_reset,
  // Peripherals
  input  wire logic                         disk_op_start,
  input  wire logic                         disk_op_done,
  input  wire logic                         disk_parity_err,
  input  wire logic                         tape_busy_in,
  input  wire logic                         tape_rw_err,
  input  wire logic                         entry_on_instr,
  input  wire logic                         entry_off_instr,
  input  wire logic [1:0]                   term_path_sel,
  output logic                              video_terminal,
  output logic                              teletype,
  // Status-flag sources
  input  wire logic                         compare_instr,
  input  wire logic                         peripheral_select_instr,
  input  wire logic                         index_compare_instr,
  input  wire logic                         unconditional_branch_instr,
  input  wire logic                         indirect_bit,
  input  wire ccs_pkg::ccs_stat_t           cmp_result,
  input  wire logic                         arith_ovf,
  input  wire logic                         decode_strobe,
  input  wire logic                         decode_legal,
  // Console view
  output logic [7:0]                        prog_flags,
  output ccs_pkg::ccs_stat_t                stat_flags,
  output ccs_pkg::ccs_phase_t               phase,
  output logic                              shift_active_flag,
  output logic                              int_enable,
  output logic                              awaiting_entry_flag,
  output logic                              disk_busy_flag,
  output logic                              disk_error_flag,
  output logic                              tape_busy_flag,
  output logic                              tape_error_flag,
  output logic                              illegal_instr_flag,
  // AXI4-Lite slave
  input  wire logic [3:0]                   s_awaddr,
  input  wire logic                         s_awvalid,
  output logic                              s_awready,
  input  wire logic [31:0]                  s_wdata,
  input  wire logic [3:0]                   s_wstrb,
  input  wire logic                         s_wvalid,
  output logic                              s_wready,
  output logic [1:0]                        s_bresp,
  output logic                              s_bvalid,
  input  wire logic                         s_bready,
  input  wire logic [3:0]                   s_araddr,
  input  wire logic                         s_arvalid,
  output logic                              s_arready,
  output logic [31:0]                       s_rdata,
  output logic [1:0]                        s_rresp,
  output logic                              s_rvalid,
  input  wire logic                         s_rready
);
  import ccs_pkg::*;

  logic [31:0] state_word;
  logic [31:0] flag_word;
  logic        wr_fire;
  logic [3:0]  aw_addr_reg;
  logic        aw_got_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_got_reg;
  logic        sw_panel;
  logic        clr_derr;
  logic        clr_terr;
  logic        clr_ill;
  logic        panel_any;
  logic        path_ok;

  // Legal path decode, used by awaiting-entry logic; routing compares the codes directly
  function automatic logic path_legal(input logic [1:0] sel);
    path_legal = (sel == CCS_PATH_VIDEO) || (sel == CCS_PATH_TTY);
  endfunction : path_legal

  // ----------------------------------------------------------------
  // Cycle phase
  // ----------------------------------------------------------------
  // Phase advances at each memory cycle start; one state means one flag
  // one phase only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_IDLE;
    end else if (cycle_start) begin
      unique case (cycle_req)
        PH_FETCH:   phase <= PH_FETCH;
        PH_OPERAND: phase <= mem_ref_instr ? PH_OPERAND : PH_IDLE;
        PH_EXEC1:   phase <= multi_cycle_instr ? PH_EXEC1 : PH_IDLE;
        PH_EXEC2:   phase <= (exec2_instr && phase == PH_EXEC1) ? PH_EXEC2 : PH_IDLE;
        PH_IDLE:    phase <= PH_IDLE;
        default:    phase <= PH_IDLE;  // Undefined request code
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Programmable flags and branch test
  // ----------------------------------------------------------------
  // set and clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_flags <= CCS_PROG_RST;
    end else if (flag_sel < CCS_SEL_WRAP) begin
      if (set_flag_instr) begin
        prog_flags[flag_sel[2:0]] <= 1'b1;
      end else if (reset_flag_instr) begin
        prog_flags[flag_sel[2:0]] <= 1'b0;
      end
    end
  end

  // Test samples only the eight flags; the wrap flag has no path here
  // per-flag test
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_test_valid  <= 1'b0;
      flag_test_result <= 1'b0;
    end else begin
      flag_test_valid  <= branch_on_flag_instr;
      if (branch_on_flag_instr) begin
        flag_test_result <= (flag_sel < CCS_SEL_WRAP) && prog_flags[flag_sel[2:0]];
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift and interrupt enable
  // ----------------------------------------------------------------
  // nonzero shifts only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_active_flag <= 1'b0;
    end else if (shift_start) begin
      shift_active_flag <= (shift_count != 5'h00);
    end else if (shift_done) begin
      shift_active_flag <= 1'b0;
    end
  end

  assign panel_any = panel_reset | sw_panel;

  // Enable wins if issued together with a clear source
  // enable instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_enable <= 1'b0;
    end else if (int_enable_instr) begin
      int_enable <= 1'b1;
    end else if (int_disable_instr || int_taken || panel_any) begin
      int_enable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral flags
  // ----------------------------------------------------------------
  // disc busy span
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disk_busy_flag <= 1'b0;
    end else if (disk_op_start) begin
      disk_busy_flag <= 1'b1;
    end else if (disk_op_done) begin
      disk_busy_flag <= 1'b0;
    end
  end

  // Sticky errors; a new error in the clearing cycle is kept
  // disc error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      disk_error_flag    <= 1'b0;
      tape_error_flag    <= 1'b0;
      tape_busy_flag     <= 1'b0;
      illegal_instr_flag <= 1'b0;
    end else begin
      tape_busy_flag <= tape_busy_in;
      if (disk_parity_err) begin
        disk_error_flag <= 1'b1;
      end else if (clr_derr) begin
        disk_error_flag <= 1'b0;
      end
      if (tape_rw_err) begin
        tape_error_flag <= 1'b1;
      end else if (clr_terr) begin
        tape_error_flag <= 1'b0;
      end
      if (decode_strobe && !decode_legal) begin
        illegal_instr_flag <= 1'b1;
      end else if (clr_ill) begin
        illegal_instr_flag <= 1'b0;
      end
    end
  end

  // Mixed select codes reach neither device
  // path decode
  assign path_ok = path_legal(term_path_sel);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      video_terminal <= 1'b0;
      teletype       <= 1'b0;
    end else begin
      video_terminal <= (term_path_sel == CCS_PATH_VIDEO);
      teletype       <= (term_path_sel == CCS_PATH_TTY);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awaiting_entry_flag <= 1'b0;
    end else if (entry_on_instr && path_ok) begin
      awaiting_entry_flag <= 1'b1;
    end else if ((entry_off_instr && path_ok) || panel_any) begin
      awaiting_entry_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // compare updates
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_flags <= CCS_STAT_RST;
    end else begin
      if (compare_instr || peripheral_select_instr ||
          (unconditional_branch_instr && indirect_bit)) begin
        stat_flags.greater   <= cmp_result.greater;
        stat_flags.match     <= cmp_result.match;
        stat_flags.less      <= cmp_result.less;
        stat_flags.bit_match <= cmp_result.bit_match;
      end else if (index_compare_instr) begin
        stat_flags.greater   <= cmp_result.greater;
        stat_flags.match     <= cmp_result.match;
        stat_flags.less      <= cmp_result.less;
      end
      if (arith_ovf || (set_flag_instr && flag_sel == CCS_SEL_WRAP)) begin
        stat_flags.arith_wrap <= 1'b1;
      end else if (unconditional_branch_instr && indirect_bit) begin
        stat_flags.arith_wrap <= cmp_result.arith_wrap;
      end else if (reset_flag_instr && flag_sel == CCS_SEL_WRAP) begin
        stat_flags.arith_wrap <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data latched independently, either may come first
  assign s_awready = !aw_got_reg && !s_bvalid;
  assign s_wready  = !w_got_reg && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign wr_fire   = aw_got_reg && w_got_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_reg  <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_got_reg   <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else if (wr_fire) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_bvalid <= 1'b0;
      s_bresp  <= CCS_RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid <= 1'b1;
      s_bresp  <= (aw_addr_reg == CCS_ADDR_STATE || aw_addr_reg == CCS_ADDR_CTRL ||
                   aw_addr_reg == CCS_ADDR_FLAGS) ? CCS_RESP_OKAY : CCS_RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Decoded write strobes, single-cycle
  assign clr_derr = wr_fire && aw_addr_reg == CCS_ADDR_STATE && w_strb_reg[1] &&
                    w_data_reg[CCS_ST_DERR];
  assign clr_terr = wr_fire && aw_addr_reg == CCS_ADDR_STATE && w_strb_reg[1] &&
                    w_data_reg[CCS_ST_TERR];
  assign clr_ill  = wr_fire && aw_addr_reg == CCS_ADDR_STATE && w_strb_reg[1] &&
                    w_data_reg[CCS_ST_ILLEGAL];
  assign sw_panel = wr_fire && aw_addr_reg == CCS_ADDR_CTRL && w_strb_reg[0] &&
                    w_data_reg[CCS_CTRL_PANEL];

  // Read words; unused bits read zero
  always_comb begin
    state_word = 32'h0000_0000;
    state_word[CCS_ST_FETCH]   = (phase == PH_FETCH);
    state_word[CCS_ST_OPERAND] = (phase == PH_OPERAND);
    state_word[CCS_ST_EXEC1]   = (phase == PH_EXEC1);
    state_word[CCS_ST_EXEC2]   = (phase == PH_EXEC2);
    state_word[CCS_ST_SHIFT]   = shift_active_flag;
    state_word[CCS_ST_IEN]     = int_enable;
    state_word[CCS_ST_ENTRY]   = awaiting_entry_flag;
    state_word[CCS_ST_DBUSY]   = disk_busy_flag;
    state_word[CCS_ST_DERR]    = disk_error_flag;
    state_word[CCS_ST_TBUSY]   = tape_busy_flag;
    state_word[CCS_ST_TERR]    = tape_error_flag;
    state_word[CCS_ST_ILLEGAL] = illegal_instr_flag;
    flag_word = 32'h0000_0000;
    flag_word[CCS_NUM_PROG-1:0] = prog_flags;
    flag_word[CCS_STAT_LSB +: 5] = stat_flags;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= CCS_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp  <= CCS_RESP_OKAY;
      unique case (s_araddr)
        CCS_ADDR_STATE: s_rdata <= state_word;
        CCS_ADDR_FLAGS: s_rdata <= flag_word;
        CCS_ADDR_CTRL:  s_rdata <= 32'h0000_0000;
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= CCS_RESP_SLVERR;
        end
      endcase
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_exec1_cycle;
    cycle_start && phase == PH_EXEC1;
  endsequence
  sequence s_exec2_req;
    cycle_req == PH_EXEC2 && exec2_instr;
  endsequence

  a_fetch_phase_entry: assert property (
    cycle_start && cycle_req == PH_FETCH |=> phase == PH_FETCH)
    else $error("fetch phase not entered");
  a_operand_needs_memref: assert property (
    cycle_start && cycle_req == PH_OPERAND && !mem_ref_instr |=> phase == PH_IDLE)
    else $error("operand phase without memory reference");
  a_exec1_entry: assert property (
    cycle_start && cycle_req == PH_EXEC1 && multi_cycle_instr |=> phase == PH_EXEC1)
    else $error("first execution phase missing");
  a_exec2_after_exec1: assert property (
    (s_exec1_cycle and s_exec2_req) |=> phase == PH_EXEC2)
    else $error("second execution phase missing");
  // Next memory cycle always leaves the second execution phase
  a_exec2_one_cycle: assert property (
    cycle_start && phase == PH_EXEC2 |=> phase != PH_EXEC2)
    else $error("second execution phase held too long");
  a_exec2_origin: assert property (
    $rose(phase == PH_EXEC2) |-> $past(phase) == PH_EXEC1)
    else $error("second execution phase without first");
  a_prog_flag_set: assert property (
    set_flag_instr && flag_sel < CCS_SEL_WRAP |=> prog_flags[$past(flag_sel[2:0])])
    else $error("programmable flag not set");
  a_flag_test_value: assert property (
    branch_on_flag_instr && flag_sel < CCS_SEL_WRAP
    |=> flag_test_valid && flag_test_result == $past(prog_flags[flag_sel[2:0]]))
    else $error("flag test result wrong");
  a_shift_zero_count: assert property (
    shift_start && shift_count == 5'h00 |=> !shift_active_flag)
    else $error("shift flag set for zero count");
  a_ien_clear_src: assert property (
    !int_enable_instr && (int_disable_instr || int_taken || panel_reset) |=> !int_enable)
    else $error("interrupt enable not cleared");
  a_entry_set_path: assert property (
    entry_on_instr && term_path_sel == CCS_PATH_VIDEO |=> awaiting_entry_flag)
    else $error("awaiting entry not set");
  a_wrap_hold_value: assert property (
    !arith_ovf && !(unconditional_branch_instr && indirect_bit) &&
    !((set_flag_instr || reset_flag_instr) && flag_sel == CCS_SEL_WRAP)
    |=> $stable(stat_flags.arith_wrap))
    else $error("wrap flag changed without cause");
  a_illegal_raise: assert property (
    decode_strobe && !decode_legal
    |=> illegal_instr_flag ##1 (illegal_instr_flag || $past(clr_ill)))
    else $error("illegal instruction not flagged");
  a_write_resp_time: assert property (
    s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("write response late");

endmodule : ccs_flags

`default_nettype wire

// File: common/ccs_pkg.sv
// Shared constants and types for the CPU cycle-state and flag block
package ccs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] CCS_ADDR_STATE = 4'h0;  // Phase and device flags, W1C errors
  localparam logic [3:0] CCS_ADDR_FLAGS = 4'h4;  // Programmable and status flags
  localparam logic [3:0] CCS_ADDR_CTRL  = 4'h8;  // Self-clearing control strobes

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CCS_NUM_PROG      = 8;   // Programmable flag count
  localparam int CCS_STAT_LSB      = 19;  // Status flags sit in bits 19..23
  localparam int CCS_SEL_W         = 4;   // Flag select width
  localparam logic [3:0] CCS_SEL_WRAP = 4'h8;  // Select code of the wrap flag
  localparam int CCS_ST_FETCH      = 0;
  localparam int CCS_ST_OPERAND    = 1;
  localparam int CCS_ST_EXEC1      = 2;
  localparam int CCS_ST_EXEC2      = 3;
  localparam int CCS_ST_SHIFT      = 4;
  localparam int CCS_ST_IEN        = 5;
  localparam int CCS_ST_ENTRY      = 6;
  localparam int CCS_ST_DBUSY      = 7;
  localparam int CCS_ST_DERR       = 8;
  localparam int CCS_ST_TBUSY      = 9;
  localparam int CCS_ST_TERR       = 10;
  localparam int CCS_ST_ILLEGAL    = 11;
  localparam int CCS_CTRL_PANEL    = 0;   // Write 1: soft front-panel reset

  // ----------------------------------------------------------------
  // Reset values and path codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  CCS_PROG_RST  = 8'h00;
  localparam logic [1:0]  CCS_PATH_VIDEO = 2'h0;  // Both selects low
  localparam logic [1:0]  CCS_PATH_TTY   = 2'h3;  // Both selects high
  localparam logic [1:0]  CCS_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  CCS_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE, PH_FETCH, PH_OPERAND, PH_EXEC1, PH_EXEC2
  } ccs_phase_t;

  typedef struct packed {
    logic greater;
    logic match;
    logic less;
    logic bit_match;
    logic arith_wrap;
  } ccs_stat_t;

  localparam ccs_stat_t CCS_STAT_RST = '0;

endpackage : ccs_pkg

// File: tb/ccs_seq_model.sv
// Sequencer model walking one memory-update instruction through its phases
`timescale 1ns/1ps
`default_nettype none
module ccs_seq_model (
  input  wire logic           clk,
  input  wire logic           go,
  input  wire logic           qual,
  output ccs_pkg::ccs_phase_t cycle_req,
  output logic                cycle_start,
  output logic                mem_ref_instr,
  output logic                multi_cycle_instr,
  output logic                exec2_instr
);
  import ccs_pkg::*;
  // Qualifiers follow qual; a low walk exercises the refused phases
  assign mem_ref_instr = qual;
  assign multi_cycle_instr = qual;
  assign exec2_instr = qual;
  // phases in order, one start pulse per memory cycle
  initial begin
    cycle_req = PH_IDLE;
    cycle_start = 1'h0;
    forever begin
      @(posedge clk);
      if (go) begin
        for (int i = 1; i <= 4; i++) begin
          cycle_req <= ccs_phase_t'(i);
          cycle_start <= 1'h1;
          @(posedge clk);
          cycle_start <= 1'h0;
          @(posedge clk);
        end
      end
    end
  end
endmodule : ccs_seq_model
`default_nettype wire

// File: tb/ccs_flags_tb.sv
// Self-checking bench for the cycle-state and flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
`define P(s) begin @(posedge clk); s <= 1'h1; @(posedge clk); s <= 1'h0; @(negedge clk); end
module ccs_flags_tb;
  import ccs_pkg::*;
  int fail_count = 0, n_compared = 0;
  logic clk = '0, rst_n = '0, go = '0, set_flag_instr = '0, reset_flag_instr = '0, int_taken = '0;
  logic branch_on_flag_instr = '0, int_enable_instr = '0, int_disable_instr = '0, panel_reset = '0;
  logic shift_start = '0, shift_done = '0, disk_op_start = '0, disk_op_done = '0, tape_busy_in = '0;
  logic disk_parity_err = '0, tape_rw_err = '0, entry_on_instr = '0, entry_off_instr = '0;
  logic compare_instr = '0, peripheral_select_instr = '0, index_compare_instr = '0, indirect_bit = '0;
  logic unconditional_branch_instr = '0, arith_ovf = '0, decode_strobe = '0, decode_legal = '0;
  logic s_awvalid = '0, s_wvalid = '0, s_bready = '0, s_arvalid = '0, s_rready = '0;
  logic [3:0] flag_sel = '0, s_awaddr = '0, s_araddr = '0, s_wstrb = 4'hF;
  logic [4:0] shift_count = '0;
  logic qual = '1;
  logic [1:0] term_path_sel = '0, s_bresp, s_rresp, rd_r;
  logic [31:0] s_wdata = '0, s_rdata, rd_d;
  logic [7:0] prog_flags;
  ccs_stat_t cmp_result = '0, stat_flags;
  ccs_phase_t cycle_req, phase;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, flag_test_valid, flag_test_result;
  logic cycle_start, mem_ref_instr, multi_cycle_instr, exec2_instr, video_terminal, teletype;
  logic shift_active_flag, int_enable, awaiting_entry_flag, disk_busy_flag, disk_error_flag;
  logic tape_busy_flag, tape_error_flag, illegal_instr_flag;
  ccs_flags dut (.*);
  ccs_seq_model seq (.*);
  initial forever #2.5 clk = ~clk;
  // Whole run is under two hundred cycles; the limit leaves ample margin
  initial begin
    #20000;
    fail_count++;
    stop_test;
  end
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  // Bus cycles: both write halves offered together, s_bready and s_rready idle low
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    do @(negedge clk); while (!(s_awready && s_wready));
    @(posedge clk);
    s_awvalid <= 1'h0;
    s_wvalid <= 1'h0;
    do @(negedge clk); while (!s_bvalid);
    rd_r = s_bresp;
    @(posedge clk);
    s_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    do @(negedge clk); while (!s_arready);
    @(posedge clk);
    s_arvalid <= 1'h0;
    do @(negedge clk); while (!s_rvalid);
    {rd_r, rd_d} = {s_rresp, s_rdata};
    @(posedge clk);
    s_rready <= 1'h0;
  endtask : rd
  task automatic t_prog;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      flag_sel <= 4'(i);
      `P(set_flag_instr)
    end
    `CHK("prog", 9'h1FF, {stat_flags.arith_wrap, prog_flags})
    @(posedge clk);
    flag_sel <= 4'h5;
    `P(branch_on_flag_instr)
    `CHK("test", 2'h3, {flag_test_valid, flag_test_result})
    `P(reset_flag_instr)
    `P(branch_on_flag_instr)
    `CHK("test", 10'h2DF, {flag_test_valid, flag_test_result, prog_flags})
    $display("t_prog done");
  endtask : t_prog
  task automatic t_ien;
    `P(int_enable_instr)
    `P(entry_on_instr)
    `CHK("ien", 3'h7, {int_enable, awaiting_entry_flag, video_terminal})
    `P(int_taken)
    `CHK("ien", 1'h0, int_enable)
    `P(int_enable_instr)
    `P(int_disable_instr)
    `CHK("ien", 1'h0, int_enable)
    `P(int_enable_instr)
    `P(panel_reset)
    `CHK("panel", 10'h0DF, {int_enable, awaiting_entry_flag, prog_flags})
    @(posedge clk);
    term_path_sel <= CCS_PATH_TTY;
    `P(entry_on_instr)
    `CHK("tty", 3'h5, {awaiting_entry_flag, video_terminal, teletype})
    `P(entry_off_instr)
    `CHK("entry", 1'h0, awaiting_entry_flag)
    $display("t_ien done");
  endtask : t_ien
  task automatic t_stat;
    @(posedge clk);
    cmp_result <= 5'h16;
    `P(compare_instr)
    `CHK("stat", 5'h17, stat_flags)
    rd(CCS_ADDR_FLAGS);
    `CHK("flags", {8'h00, 5'h17, 11'h000, 8'hDF}, rd_d)
    @(posedge clk);
    flag_sel <= CCS_SEL_WRAP;
    cmp_result <= 5'h08;
    `P(reset_flag_instr)
    `P(index_compare_instr)
    `CHK("idx", 4'h4, {stat_flags.greater, stat_flags.match, stat_flags.less, stat_flags.arith_wrap})
    `P(arith_ovf)
    `CHK("ovf", 1'h1, stat_flags.arith_wrap)
    @(posedge clk);
    indirect_bit <= 1'h1;
    cmp_result <= 5'h12;
    `P(unconditional_branch_instr)
    `CHK("bru", 5'h12, stat_flags)
    $display("t_stat done");
  endtask : t_stat
  // Second walk has the qualifiers low: only the fetch phase may appear
  task automatic t_phase;
    for (int q = 1; q >= 0; q--) begin
      @(posedge clk);
      go <= 1'h1;
      qual <= 1'(q);
      @(posedge clk);
      go <= 1'h0;
      for (int i = 1; i <= 4; i++) begin
        @(posedge clk);
        @(negedge clk);
        `CHK("phase", (q == 1 || i == 1) ? ccs_phase_t'(i) : PH_IDLE, phase)
        @(posedge clk);
      end
    end
    $display("t_phase done");
  endtask : t_phase
  task automatic t_dev;
    @(posedge clk);
    shift_count <= 5'h03;
    tape_busy_in <= 1'h1;
    `P(shift_start)
    `P(disk_op_start)
    `P(tape_rw_err)
    `P(int_enable_instr)
    `CHK("dev", 5'h1F, {shift_active_flag, disk_busy_flag, tape_busy_flag, tape_error_flag, int_enable})
    @(posedge clk);
    shift_count <= 5'h00;
    tape_busy_in <= 1'h0;
    `P(shift_done)
    `P(disk_op_done)
    `P(shift_start)
    wr(CCS_ADDR_CTRL, 32'h0000_0001);
    `CHK("dev", 7'h08, {shift_active_flag, disk_busy_flag, tape_busy_flag, tape_error_flag, int_enable, rd_r})
    wr(CCS_ADDR_STATE, 32'h0000_0400);
    `CHK("terr", 1'h0, tape_error_flag)
    $display("t_dev done");
  endtask : t_dev
  task automatic t_err;
    `P(disk_parity_err)
    `P(decode_strobe)
    rd(CCS_ADDR_STATE);
    `CHK("err", 3'h7, {disk_error_flag, illegal_instr_flag, rd_d[CCS_ST_DERR]})
    wr(CCS_ADDR_STATE, 32'h0000_0100);
    `CHK("w1c", 2'h1, {disk_error_flag, illegal_instr_flag})
    rd(4'hC);
    `CHK("unmapped", {CCS_RESP_SLVERR, 32'h0}, {rd_r, rd_d})
    wr(4'hC, 32'h0000_0000);
    `CHK("unmapped", CCS_RESP_SLVERR, rd_r)
    $display("t_err done");
  endtask : t_err
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    t_prog;
    t_ien;
    t_stat;
    t_phase;
    t_dev;
    t_err;
    stop_test;
  end
endmodule : ccs_flags_tb
`default_nettype wire
